//--- hw/maa_averager.sv
// Averager that accumulates a power-of-two number of signed samples and emits their mean.
`timescale 1ns/1ps

module maa_averager
  import maa_pkg::*;
#(
  parameter int DATA_W = 16,  // Sample width.
  parameter int CNT_W  = 11   // Counter width, covers 1024 samples.
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [2:0]               avg_code,
  input  wire logic                     in_valid,
  input  wire logic signed [DATA_W-1:0] in_data,
  output logic                          out_valid,
  output logic signed [DATA_W-1:0]      out_data
);

  // ---------------------------------------------------------------------------
  // Accumulator state
  // ---------------------------------------------------------------------------
  localparam int ACC_W = DATA_W + CNT_W;  // Holds 1024 full-scale samples without overflow.

  logic signed [ACC_W-1:0]  acc_q, acc_d;        // Running sum of the current run.
  logic [CNT_W-1:0]         cnt_q, cnt_d;        // Samples already summed in this run.
  logic                     valid_q, valid_d;    // One-cycle result strobe.
  logic signed [DATA_W-1:0] data_q, data_d;      // Last averaged result.
  logic signed [ACC_W-1:0]  acc_sum;             // Sum including the incoming sample.
  logic signed [ACC_W-1:0]  acc_shift;           // Sum divided by the sample count.

  // Next-state logic: a run ends on the sample whose index reaches the last one.
  // If software shrinks the count to or below the samples already summed, the run ends
  // at once on the next sample, which gives one sum scaled by the new count rather than a stuck counter.
  always_comb begin
    acc_sum   = acc_q + ACC_W'(in_data);
    acc_shift = acc_sum >>> maa_avg_shift(avg_code);
    acc_d     = acc_q;
    cnt_d     = cnt_q;
    valid_d   = 1'b0;
    data_d    = data_q;
    if (in_valid) begin
      if (cnt_q >= maa_avg_last(avg_code)) begin
        acc_d   = '0;
        cnt_d   = '0;
        valid_d = 1'b1;
        data_d  = acc_shift[DATA_W-1:0];
      end else begin
        acc_d = acc_sum;
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  // Registers only.
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q   <= '0;
      cnt_q   <= '0;
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      acc_q   <= acc_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  assign out_valid = valid_q;
  assign out_data  = data_q;

endmodule : maa_averager

//--- hw/maa_pkg.sv
// Package of constants, types and helper functions for the monitor ADC averaging and alarm block.
package maa_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int MAA_DATA_W = 16;  // Width of a conversion code and of a register.
  localparam int MAA_ADDR_W = 8;   // Width of the register port address.
  localparam int MAA_CNT_W  = 11;  // Sample counter width, enough for 1024 samples.
  localparam int MAA_HYST_W = 8;   // Width of each hysteresis field.

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MAA_OFS_AVG_CFG   = 8'h42;  // Averaging configuration.
  localparam logic [7:0] MAA_OFS_BYPASS    = 8'h44;  // Data bypass word.
  localparam logic [7:0] MAA_OFS_HYST_TV   = 8'h46;  // Temperature and voltage hysteresis.
  localparam logic [7:0] MAA_OFS_HYST_SH   = 8'h47;  // Shunt hysteresis.
  localparam logic [7:0] MAA_OFS_SH0_UPPER = 8'h50;  // Shunt channel 0 upper threshold.

  // ---------------------------------------------------------------------------
  // Field positions (least significant bit of each field)
  // ---------------------------------------------------------------------------
  localparam int MAA_POS_AVG_TEMP  = 8;  // temp_average_count field.
  localparam int MAA_POS_AVG_VOLT  = 4;  // voltage_average_count field.
  localparam int MAA_POS_AVG_SHUNT = 0;  // shunt_average_count field.
  localparam int MAA_POS_HYST_TEMP = 8;  // temp_hysteresis field.
  localparam int MAA_POS_HYST_VOLT = 0;  // Voltage hysteresis field.
  localparam int MAA_POS_HYST_SH   = 0;  // Shunt hysteresis field.

  // Writable bits of the averaging configuration; all other bits read as zero.
  localparam logic [15:0] MAA_AVG_CFG_MASK = 16'h0777;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MAA_RST_AVG_CFG   = 16'h0000;
  localparam logic [15:0] MAA_RST_BYPASS    = 16'h0000;
  localparam logic [15:0] MAA_RST_HYST_TV   = 16'h0808;
  localparam logic [15:0] MAA_RST_HYST_SH   = 16'h0008;
  localparam logic [15:0] MAA_RST_SH0_UPPER = 16'h7FFF;
  localparam logic        MAA_RST_SPAN_SEL  = 1'h0;

  // ---------------------------------------------------------------------------
  // Sample categories
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MAA_KIND_TEMP  = 2'h0,
    MAA_KIND_VOLT  = 2'h1,
    MAA_KIND_SHUNT = 2'h2
  } maa_kind_e;

  localparam int MAA_NUM_KINDS = 3;  // Number of averaging categories.

  // ---------------------------------------------------------------------------
  // Averaging code decode: counts are powers of two, so the mean is a shift.
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] maa_avg_shift(input logic [2:0] code);
    logic [3:0] sh;
    case (code)
      3'h0:    sh = 4'h0;  // 1 sample.
      3'h1:    sh = 4'h2;  // 4 samples.
      3'h2:    sh = 4'h4;  // 16 samples.
      3'h3:    sh = 4'h6;  // 64 samples.
      3'h4:    sh = 4'h7;  // 128 samples.
      3'h5:    sh = 4'h8;  // 256 samples.
      3'h6:    sh = 4'h9;  // 512 samples.
      default: sh = 4'hA;  // 1024 samples.
    endcase
    return sh;
  endfunction : maa_avg_shift

  // Index of the last sample of a run for a given averaging code.
  function automatic logic [MAA_CNT_W-1:0] maa_avg_last(input logic [2:0] code);
    logic [MAA_CNT_W:0] n;
    n = (MAA_CNT_W+1)'(1) << maa_avg_shift(code);
    return MAA_CNT_W'(n - (MAA_CNT_W+1)'(1));
  endfunction : maa_avg_last

endpackage : maa_pkg

//--- hw/maa_top.sv
// Top of the monitor ADC post-conversion block: averaging, bypass, hysteresis and shunt alarm.
`timescale 1ns/1ps

module maa_top
(
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Register port.
  input  wire logic                         reg_wr_en,
  input  wire logic                         reg_rd_en,
  input  wire logic [maa_pkg::MAA_ADDR_W-1:0] reg_addr,
  input  wire logic [maa_pkg::MAA_DATA_W-1:0] reg_wr_data,
  output logic [maa_pkg::MAA_DATA_W-1:0]      reg_rd_data,
  output logic                              reg_rd_valid,
  // Loose control bits held elsewhere in the device.
  input  wire logic                         bypass_enable,
  input  wire logic                         shunt_range,
  output logic                              shunt_span_sel,
  input  wire logic [maa_pkg::MAA_DATA_W-1:0] shunt0_lower_limit,
  // Raw conversion stream from the converter.
  input  wire logic                         sample_valid,
  input  wire logic [1:0]                   sample_kind,
  input  wire logic [maa_pkg::MAA_DATA_W-1:0] sample_data,
  // Averaged results.
  output logic                              temp_result_valid,
  output logic [maa_pkg::MAA_DATA_W-1:0]      temp_result,
  output logic                              volt_result_valid,
  output logic [maa_pkg::MAA_DATA_W-1:0]      volt_result,
  output logic                              shunt_result_valid,
  output logic [maa_pkg::MAA_DATA_W-1:0]      shunt_result,
  // Hysteresis values for the alarm logic of the other categories.
  output logic [maa_pkg::MAA_HYST_W-1:0]      temp_hysteresis,
  output logic [maa_pkg::MAA_HYST_W-1:0]      volt_hysteresis,
  output logic [maa_pkg::MAA_HYST_W-1:0]      shunt_hysteresis,
  // Shunt channel 0 alarm status.
  output logic                              shunt0_alarm
);

  import maa_pkg::*;

  // ---------------------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------------------
  logic [MAA_DATA_W-1:0] avg_cfg_q,   avg_cfg_d;    // averaging_config.
  logic [MAA_DATA_W-1:0] bypass_q,    bypass_d;     // data_bypass_value.
  logic [MAA_DATA_W-1:0] hyst_tv_q,   hyst_tv_d;    // hysteresis_temp_voltage.
  logic [MAA_DATA_W-1:0] hyst_sh_q,   hyst_sh_d;    // hysteresis_shunt.
  logic [MAA_DATA_W-1:0] upper_q,     upper_d;      // shunt0_upper_threshold.
  logic [MAA_DATA_W-1:0] rd_data_q,   rd_data_d;    // Registered read answer.
  logic                  rd_valid_q,  rd_valid_d;   // Read answer strobe.

  // Register writes. Reserved bits are masked so they always read back as zero.
  always_comb begin
    avg_cfg_d = avg_cfg_q;
    bypass_d  = bypass_q;
    hyst_tv_d = hyst_tv_q;
    hyst_sh_d = hyst_sh_q;
    upper_d   = upper_q;
    if (reg_wr_en) begin
      case (reg_addr)
        MAA_OFS_AVG_CFG:   avg_cfg_d = reg_wr_data & MAA_AVG_CFG_MASK;
        MAA_OFS_BYPASS:    bypass_d  = reg_wr_data;
        MAA_OFS_HYST_TV:   hyst_tv_d = reg_wr_data;
        MAA_OFS_HYST_SH:   hyst_sh_d = {8'h00, reg_wr_data[7:0]};
        MAA_OFS_SH0_UPPER: upper_d   = reg_wr_data;
        default: begin
          // Writes to unmapped offsets are dropped.
        end
      endcase
    end
  end

  // Read decode. Unmapped offsets answer zero so software never sees stale data.
  always_comb begin
    rd_valid_d = reg_rd_en;
    rd_data_d  = rd_data_q;
    if (reg_rd_en) begin
      case (reg_addr)
        MAA_OFS_AVG_CFG:   rd_data_d = avg_cfg_q;
        MAA_OFS_BYPASS:    rd_data_d = bypass_q;
        MAA_OFS_HYST_TV:   rd_data_d = hyst_tv_q;
        MAA_OFS_HYST_SH:   rd_data_d = hyst_sh_q;
        MAA_OFS_SH0_UPPER: rd_data_d = upper_q;
        default:           rd_data_d = '0;
      endcase
    end
  end

  // Register file flip-flops with their documented reset values.
  always_ff @(posedge clock) begin
    if (rst) begin
      avg_cfg_q  <= MAA_RST_AVG_CFG;
      bypass_q   <= MAA_RST_BYPASS;
      hyst_tv_q  <= MAA_RST_HYST_TV;
      hyst_sh_q  <= MAA_RST_HYST_SH;
      upper_q    <= MAA_RST_SH0_UPPER;
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      avg_cfg_q  <= avg_cfg_d;
      bypass_q   <= bypass_d;
      hyst_tv_q  <= hyst_tv_d;
      hyst_sh_q  <= hyst_sh_d;
      upper_q    <= upper_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign reg_rd_data      = rd_data_q;
  assign reg_rd_valid     = rd_valid_q;
  assign temp_hysteresis  = hyst_tv_q[MAA_POS_HYST_TEMP +: MAA_HYST_W];
  assign volt_hysteresis  = hyst_tv_q[MAA_POS_HYST_VOLT +: MAA_HYST_W];
  assign shunt_hysteresis = hyst_sh_q[MAA_POS_HYST_SH +: MAA_HYST_W];

  // ---------------------------------------------------------------------------
  // Shunt span selection
  // ---------------------------------------------------------------------------
  // The range bit only changes the analog gain; the digital scale stays at
  // 1.25 uV per code in both ranges, so nothing downstream is rescaled here.
  logic span_q, span_d;  // Registered span select toward the front end.

  always_comb begin
    span_d = shunt_range;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      span_q <= MAA_RST_SPAN_SEL;
    end else begin
      span_q <= span_d;
    end
  end

  assign shunt_span_sel = span_q;

  // ---------------------------------------------------------------------------
  // Bypass and per-category averaging
  // ---------------------------------------------------------------------------
  logic [MAA_DATA_W-1:0] src_data;                       // Data after bypass selection.
  logic [2:0]            avg_code  [MAA_NUM_KINDS];      // Averaging code per category.
  logic                  avg_in_v  [MAA_NUM_KINDS];      // Sample strobe per category.
  logic                  avg_out_v [MAA_NUM_KINDS];      // Result strobe per category.
  logic [MAA_DATA_W-1:0] avg_out_d [MAA_NUM_KINDS];      // Result per category.

  // The bypass word stands in for the converter's data but keeps the converter's
  // timing and category, so averaging and alarms can be exercised from software.
  always_comb begin
    src_data = bypass_enable ? bypass_q : sample_data;
    avg_code[MAA_KIND_TEMP]  = avg_cfg_q[MAA_POS_AVG_TEMP  +: 3];
    avg_code[MAA_KIND_VOLT]  = avg_cfg_q[MAA_POS_AVG_VOLT  +: 3];
    avg_code[MAA_KIND_SHUNT] = avg_cfg_q[MAA_POS_AVG_SHUNT +: 3];
    for (int k = 0; k < MAA_NUM_KINDS; k++) begin
      avg_in_v[k] = sample_valid && (sample_kind == 2'(k));
    end
  end

  // One averager per category; sample kind 3 is ignored.
  for (genvar g = 0; g < MAA_NUM_KINDS; g++) begin : g_avg
    maa_averager #(
      .DATA_W (MAA_DATA_W),
      .CNT_W  (MAA_CNT_W)
    ) u_avg (
      .clock     (clock),
      .rst       (rst),
      .avg_code  (avg_code[g]),
      .in_valid  (avg_in_v[g]),
      .in_data   (src_data),
      .out_valid (avg_out_v[g]),
      .out_data  (avg_out_d[g])
    );
  end

  assign temp_result_valid  = avg_out_v[MAA_KIND_TEMP];
  assign temp_result        = avg_out_d[MAA_KIND_TEMP];
  assign volt_result_valid  = avg_out_v[MAA_KIND_VOLT];
  assign volt_result        = avg_out_d[MAA_KIND_VOLT];
  assign shunt_result_valid = avg_out_v[MAA_KIND_SHUNT];
  assign shunt_result       = avg_out_d[MAA_KIND_SHUNT];

  // ---------------------------------------------------------------------------
  // Shunt channel 0 window alarm with hysteresis
  // ---------------------------------------------------------------------------
  // Bounds are formed one bit wider than the codes so that the upper threshold
  // minus hysteresis, or the lower plus hysteresis, can never wrap around.
  logic signed [MAA_DATA_W:0] res_x;       // Averaged result, sign-extended.
  logic signed [MAA_DATA_W:0] up_x;        // Upper threshold, sign-extended.
  logic signed [MAA_DATA_W:0] lo_x;        // Lower threshold, sign-extended.
  logic signed [MAA_DATA_W:0] hyst_x;      // Hysteresis, zero-extended.
  logic signed [MAA_DATA_W:0] up_clr;      // Upper clear bound.
  logic signed [MAA_DATA_W:0] lo_clr;      // Lower clear bound.
  logic                       out_window;  // Result outside the set window.
  logic                       in_band;     // Result inside the clear band.
  logic                       alarm_q, alarm_d;  // Alarm status bit.

  // Evaluation happens only on a completed average; between results the bit holds.
  // A badly programmed band (upper-hyst below lower+hyst) is the host's to avoid;
  // here it simply means the alarm can never clear, which is the safe failure.
  always_comb begin
    res_x      = (MAA_DATA_W+1)'(signed'(avg_out_d[MAA_KIND_SHUNT]));
    up_x       = (MAA_DATA_W+1)'(signed'(upper_q));
    lo_x       = (MAA_DATA_W+1)'(signed'(shunt0_lower_limit));
    hyst_x     = (MAA_DATA_W+1)'({1'b0, shunt_hysteresis});
    up_clr     = up_x - hyst_x;
    lo_clr     = lo_x + hyst_x;
    out_window = (res_x > up_x) || (res_x < lo_x);
    in_band    = (res_x <= up_clr) && (res_x >= lo_clr);
    alarm_d    = alarm_q;
    if (avg_out_v[MAA_KIND_SHUNT]) begin
      if (out_window) begin
        alarm_d = 1'b1;
      end else if (in_band) begin
        alarm_d = 1'b0;
      end
    end
  end

  // Alarm flip-flop.
  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  assign shunt0_alarm = alarm_q;

endmodule : maa_top

//--- tb/maa_chk.sv
// Checker of port timing, register answers and alarm behaviour for maa_top.
`timescale 1ns/1ps

module maa_chk
  import maa_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic                          reg_wr_en,
  input wire logic                          reg_rd_en,
  input wire logic [maa_pkg::MAA_ADDR_W-1:0] reg_addr,
  input wire logic [maa_pkg::MAA_DATA_W-1:0] reg_wr_data,
  input wire logic [maa_pkg::MAA_DATA_W-1:0] reg_rd_data,
  input wire logic                          reg_rd_valid,
  input wire logic                          shunt_range,
  input wire logic                          shunt_span_sel,
  input wire logic [maa_pkg::MAA_DATA_W-1:0] shunt0_lower_limit,
  input wire logic                          sample_valid,
  input wire logic [1:0]                    sample_kind,
  input wire logic                          temp_result_valid,
  input wire logic                          shunt_result_valid,
  input wire logic [maa_pkg::MAA_DATA_W-1:0] shunt_result,
  input wire logic [maa_pkg::MAA_HYST_W-1:0] temp_hysteresis,
  input wire logic [maa_pkg::MAA_HYST_W-1:0] volt_hysteresis,
  input wire logic                          shunt0_alarm
);
  // --------------------------------
  // Clocking and helpers
  // --------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic mapped;  // High when the address names a register.
  assign mapped = reg_addr inside {MAA_OFS_AVG_CFG, MAA_OFS_BYPASS, MAA_OFS_HYST_TV, MAA_OFS_HYST_SH,
                                   MAA_OFS_SH0_UPPER};

  // --------------------------------
  // Properties
  // --------------------------------
  property p_rd_answer;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered after one cycle");
  // Without a read the answer stays put, so a stale pulse or data change is a fault.
  property p_rd_quiet;
    !reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer moved without a read");
  property p_unmapped;
    reg_rd_en && !mapped |=> reg_rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_resv;
    reg_rd_en && reg_addr == MAA_OFS_AVG_CFG |=> (reg_rd_data & ~MAA_AVG_CFG_MASK) == 16'h0000;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv) else $error("reserved averaging bits not zero");
  property p_hsh_resv;
    reg_rd_en && reg_addr == MAA_OFS_HYST_SH |=> reg_rd_data[15:8] == 8'h00;
  endproperty
  a_hsh_resv: assert property (p_hsh_resv) else $error("shunt hysteresis upper byte not zero");
  property p_hyst_wr;
    reg_wr_en && reg_addr == MAA_OFS_HYST_TV |=> {temp_hysteresis, volt_hysteresis} == $past(reg_wr_data);
  endproperty
  a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis outputs not updated");
  property p_span;
    1'b1 |=> shunt_span_sel == $past(shunt_range);
  endproperty
  a_span: assert property (p_span) else $error("span select does not follow range input");
  // The alarm may only move when a finished average is compared.
  property p_alarm_hold;
    !shunt_result_valid |=> $stable(shunt0_alarm);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved between results");
  property p_low_set;
    shunt_result_valid && $signed(shunt_result) < $signed(shunt0_lower_limit) |=> shunt0_alarm;
  endproperty
  a_low_set: assert property (p_low_set) else $error("alarm not set below lower limit");
  property p_res_src;
    temp_result_valid |-> $past(sample_valid) && $past(sample_kind) == 2'h0;
  endproperty
  a_res_src: assert property (p_res_src) else $error("temperature result without a sample");

  // --------------------------------
  // Coverage
  // --------------------------------
  c_read: cover property (reg_rd_en ##1 reg_rd_valid);
  c_alarm_on: cover property (shunt_result_valid ##1 $rose(shunt0_alarm));
  c_alarm_off: cover property (shunt_result_valid ##1 $fell(shunt0_alarm));
endmodule : maa_chk

bind maa_top maa_chk maa_chk_inst (.clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
  .reg_rd_valid, .shunt_range, .shunt_span_sel, .shunt0_lower_limit, .sample_valid, .sample_kind,
  .temp_result_valid, .shunt_result_valid, .shunt_result, .temp_hysteresis, .volt_hysteresis, .shunt0_alarm);

//--- tb/maa_conv_model.sv
// Converter model that streams a run of conversion codes into the block.
`timescale 1ns/1ps

module maa_conv_model (
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         go,
  input wire logic [1:0]   go_kind,
  input wire logic [10:0]  go_count,
  input wire logic [15:0]  go_base,
  input wire logic [15:0]  go_step,
  output logic             sample_valid,
  output logic [1:0]       sample_kind,
  output logic [15:0]      sample_data
);
  logic [10:0] left;  // Samples still to send.
  logic [15:0] nxt;   // Next code of the ramp.

  // --------------------------------
  // Stream: back to back samples, a ramp of codes; idle data flips every cycle
  // so that a design sampling it outside a valid cycle shows it.
  // The ramp step is read live from go_step, held by the bench for the run.
  // --------------------------------
  always @(posedge clock) begin
    if (rst) begin
      left <= 11'h000;
      sample_valid <= 1'b0;
      sample_kind <= 2'h3;
      sample_data <= 16'h0000;
    end else if (left != 11'h000) begin
      sample_valid <= 1'b1;
      sample_data <= nxt;
      nxt <= nxt + go_step;
      left <= left - 11'h001;
    end else begin
      sample_valid <= 1'b0;
      sample_data <= ~sample_data;
      if (go) begin
        left <= go_count;
        nxt <= go_base;
        sample_kind <= go_kind;
      end
    end
  end
endmodule : maa_conv_model

//--- tb/test_monitor_adc_average_alarm.sv
// Self-checking bench for the averaging, bypass, hysteresis and alarm block.
`timescale 1ns/1ps

module test_monitor_adc_average_alarm;
  import maa_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, go = 1'b0;
  logic        bypass_enable = 1'b0, shunt_range = 1'b0, reg_rd_valid, shunt_span_sel;
  logic        sample_valid, temp_result_valid, volt_result_valid, shunt_result_valid, shunt0_alarm;
  logic [7:0]  reg_addr = 8'h00, temp_hysteresis, volt_hysteresis, shunt_hysteresis;
  logic [15:0] reg_wr_data = 16'h0000, shunt0_lower_limit = 16'h8000, reg_rd_data, r;
  logic [15:0] sample_data, temp_result, volt_result, shunt_result, go_base, go_step;
  logic [1:0]  sample_kind, go_kind;
  logic [10:0] go_count;
  int          num_errors = 0, samples_checked = 0, cycles = 0, c, i, e;
  int          cnt [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};  // Samples per code.
  logic [15:0] al_d [11] = '{16'h0065, 16'h005F, 16'h005C, 16'h0064, 16'hFF9C, 16'hFF9B, 16'hFFA3,
                            16'hFFA4, 16'h8000, 16'h0000, 16'hFFF0};  // Shunt codes in turn.
  logic [0:10] al_e = 11'b11000110100;  // Alarm after each code: set, hold and clear.
  wire  [2:0]  vld = {shunt_result_valid, volt_result_valid, temp_result_valid};
  wire  [47:0] resv = {shunt_result, volt_result, temp_result};

  maa_top maa_top_inst (.clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .reg_rd_valid, .bypass_enable, .shunt_range, .shunt_span_sel, .shunt0_lower_limit, .sample_valid,
    .sample_kind, .sample_data, .temp_result_valid, .temp_result, .volt_result_valid, .volt_result,
    .shunt_result_valid, .shunt_result, .temp_hysteresis, .volt_hysteresis, .shunt_hysteresis, .shunt0_alarm);
  maa_conv_model maa_conv_model_inst (.clock, .rst, .go, .go_kind, .go_count, .go_base, .go_step,
    .sample_valid, .sample_kind, .sample_data);

  // --------------------------------
  // Clock, hang guard and shared tasks
  // --------------------------------
  always #2.5 clock = ~clock;
  // The whole run needs under 5000 cycles, so 10000 means a hang.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] g);
    samples_checked++;
    if (g !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, ex, g);
    end
  endtask : chk
  // A write is taken at the second edge; the extra 1 ns lets its effect land.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [15:0] ex);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    #1;
    chk("read valid", 16'h0001, 16'(reg_rd_valid));
    chk($sformatf("register %h", a), ex, reg_rd_data);
  endtask : rchk
  // Starts a converter run, waits (bounded) for its result, then one edge for the alarm.
  task automatic run(input logic [1:0] k, input int n, input logic [15:0] b, input logic [15:0] s);
    int t;
    @(posedge clock);
    go <= 1'b1;
    go_kind <= k;
    go_count <= 11'(n);
    go_base <= b;
    go_step <= s;
    @(posedge clock);
    go <= 1'b0;
    for (t = 0; t < 1100; t++) begin
      @(posedge clock);
      #1;
      if (vld[k] === 1'b1) break;
    end
    chk("result valid", 16'h0001, 16'(vld[k]));
    r = resv[16*k +: 16];
    @(posedge clock);
    #1;
  endtask : run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rchk(MAA_OFS_AVG_CFG, 16'h0000);
    rchk(MAA_OFS_BYPASS, 16'h0000);
    rchk(MAA_OFS_HYST_TV, 16'h0808);
    rchk(MAA_OFS_HYST_SH, 16'h0008);
    rchk(MAA_OFS_SH0_UPPER, 16'h7FFF);
    rchk(8'h43, 16'h0000);
    chk("span select", 16'h0000, 16'(shunt_span_sel));
    $display("test reset values done");
    wr(MAA_OFS_AVG_CFG, 16'hFFFF);
    rchk(MAA_OFS_AVG_CFG, 16'h0777);
    wr(MAA_OFS_HYST_SH, 16'hFFA5);
    rchk(MAA_OFS_HYST_SH, 16'h00A5);
    chk("shunt hysteresis", 16'h00A5, {8'h00, shunt_hysteresis});
    wr(MAA_OFS_HYST_TV, 16'h3C5A);
    chk("hysteresis pair", 16'h3C5A, {temp_hysteresis, volt_hysteresis});
    wr(8'h45, 16'h1234);
    rchk(MAA_OFS_BYPASS, 16'h0000);
    wr(MAA_OFS_SH0_UPPER, 16'h8001);
    rchk(MAA_OFS_SH0_UPPER, 16'h8001);
    $display("test register access done");
    // Each code in turn, spread over the three categories; the mean is a floor.
    for (c = 0; c < 8; c++) begin
      wr(MAA_OFS_AVG_CFG, 16'({3'(c), 1'b0, 3'(c), 1'b0, 3'(c)}));
      run(2'(c % 3), cnt[c], 16'hFFCE, 16'h0003);
      e = (cnt[c] * -50 + 3 * cnt[c] * (cnt[c] - 1) / 2) >>> $clog2(cnt[c]);
      chk($sformatf("average code %0d", c), 16'(e), r);
    end
    $display("test averaging done");
    wr(MAA_OFS_AVG_CFG, 16'h0010);
    wr(MAA_OFS_BYPASS, 16'h0123);
    @(posedge clock);
    bypass_enable <= 1'b1;
    run(2'h1, 4, 16'h7000, 16'h0100);
    chk("bypass on", 16'h0123, r);
    @(posedge clock);
    bypass_enable <= 1'b0;
    run(2'h1, 4, 16'h0010, 16'h0010);
    chk("bypass off", 16'h0028, r);
    $display("test bypass done");
    wr(MAA_OFS_AVG_CFG, 16'h0000);
    wr(MAA_OFS_SH0_UPPER, 16'h0064);
    wr(MAA_OFS_HYST_SH, 16'h0008);
    @(posedge clock);
    shunt0_lower_limit <= 16'hFF9C;
    for (i = 0; i < 11; i++) begin
      run(2'h2, 1, al_d[i], 16'h0000);
      chk($sformatf("alarm step %0d", i), 16'(al_e[i]), 16'(shunt0_alarm));
    end
    // Single samples cross the limit but only the mean decides.
    wr(MAA_OFS_AVG_CFG, 16'h0001);
    run(2'h2, 4, 16'h00C8, 16'hFF9C);
    chk("mean alarm low", 16'h0000, 16'(shunt0_alarm));
    run(2'h2, 4, 16'h005A, 16'h000A);
    chk("mean alarm high", 16'h0001, 16'(shunt0_alarm));
    $display("test alarm done");
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      shunt_range <= (i == 0);
      repeat (2) @(posedge clock);
      #1;
      chk("span select", 16'(i == 0), 16'(shunt_span_sel));
    end
    $display("test range select done");
    close_out();
  end
endmodule : test_monitor_adc_average_alarm
